// ---- inc/pl2c_regs.vh ----
/*
  Constants for the private second-level cache controller: geometry,
  memory-type encodings, outstanding-transaction limits and reset sweep.
  Assumes it is included once per compile unit by bare name.
*/
// Summary of operation
// - Unified private cache, 8 ways, 4 banks, 64-byte lines
// - Set index and tag both taken from the physical address
// - Check bits always stored with every line; no way to disable them
// - Victims chosen by a dynamic biased replacement scheme
// - One coherent-hub link with 256-bit read and write data
// - Instruction, data, table-walk and snoop requests share one cache
// - Non-coherent instruction mode: fetch miss fills both; no instruction back-invalidate
// - Coherent instruction mode: instruction lines included; eviction invalidates them
// - Data cache strictly included; eviction invalidates matching data line
// - Reset invalidates all lines unless power mode is debug recovery
// - Only inner and outer write-back memory is cached
// - Inner write-through memory treated as non-cacheable
// - Outer write-through or non-cacheable treated as non-cacheable
// - Transient allocating read allocates in data cache as preferred victim
// - Evicted transient lines are marked not to allocate downstream
// - At most 92 outstanding link transactions in total
// - At most 92 reads, 92 writes, 92 distributed-memory operations outstanding
// - At most 53 snoops outstanding; interconnect holds further snoops
// - No own disable; data cache off means nothing cached in either level
// - Line states follow modified, exclusive, shared, invalid protocol
`ifndef PL2C_REGS_VH
`define PL2C_REGS_VH
`define PL2C_WAYS 8
`define PL2C_WAY_W 3
`define PL2C_BANK_W 2
`define PL2C_SET_W 11
`define PL2C_SETS 2048
`define PL2C_OFF_W 6
`define PL2C_PA_W 48
`define PL2C_TAG_W 31
`define PL2C_DAT_W 256
`define PL2C_ECC_W 10
`define PL2C_MAX_TOTAL 7'h5c
`define PL2C_MAX_RD 7'h5c
`define PL2C_MAX_WR 7'h5c
`define PL2C_MAX_DVM 7'h5c
`define PL2C_MAX_SNP 6'h35
`define PL2C_ATTR_NC 2'h0
`define PL2C_ATTR_WT 2'h1
`define PL2C_ATTR_WB 2'h2
`define PL2C_ST_I 2'h0
`define PL2C_ST_S 2'h1
`define PL2C_ST_E 2'h2
`define PL2C_ST_M 2'h3
`define PL2C_SRC_INS 2'h0
`define PL2C_SRC_DAT 2'h1
`define PL2C_SRC_TW 2'h2
`define PL2C_SRC_SNP 2'h3
`define PL2C_OP_RD 2'h0
`define PL2C_OP_WR 2'h1
`define PL2C_OP_DVM 2'h2
`endif

// ---- logic/pl2c_top.v ----
/*
  Private unified second-level cache controller: tag/state store with
  check bits, lookup, biased victim choice, inclusion back-invalidates,
  memory-type downgrade and outstanding-transaction accounting.
  Assumes the core holds a request until accepted and the link reports
  completions as one-cycle pulses; line data lives in an external array.
*/
`timescale 1ns/1ns
`include "pl2c_regs.vh"
module pl2c_top #(
  parameter INSTR_CACHE_COHERENCY_PARAM = 0
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  input wire dbg_recovery_i,
  // Core or snoop request
  input wire req_valid_i,
  input wire [1:0] req_src_i,
  input wire [1:0] req_op_i,
  input wire [`PL2C_PA_W-1:0] req_pa_i,
  input wire [1:0] req_inner_i,
  input wire [1:0] req_outer_i,
  input wire req_transient_i,
  input wire l1d_enable_i,
  output reg req_ready_o,
  output reg rsp_valid_o,
  output reg rsp_hit_o,
  output reg rsp_cacheable_o,
  output reg rsp_l1_prefer_evict_o,
  output reg [1:0] rsp_state_o,
  output reg [`PL2C_BANK_W-1:0] rsp_bank_o,
  output reg [`PL2C_WAY_W-1:0] rsp_way_o,
  output reg [`PL2C_ECC_W-1:0] rsp_ecc_o,
  // Link issue and completion
  output reg link_req_o,
  output reg [1:0] link_op_o,
  output reg [`PL2C_PA_W-1:0] link_pa_o,
  output reg link_no_alloc_o,
  input wire rd_done_i,
  input wire wr_done_i,
  input wire dvm_done_i,
  input wire snp_done_i,
  // First-level back-invalidates
  output reg l1i_inval_o,
  output reg l1d_inval_o,
  output reg [`PL2C_PA_W-1:0] l1_inval_pa_o,
  output reg busy_o
);
  localparam S_INIT = 3'b001;
  localparam S_IDLE = 3'b010;
  localparam S_EVIC = 3'b100;

  // Tag, state, transient flag and check bits per set and way
  reg [`PL2C_TAG_W-1:0] tag_mem [0:`PL2C_SETS*`PL2C_WAYS-1];
  reg [1:0] st_mem [0:`PL2C_SETS*`PL2C_WAYS-1];
  reg tr_mem [0:`PL2C_SETS*`PL2C_WAYS-1];
  reg [`PL2C_ECC_W-1:0] ecc_mem [0:`PL2C_SETS*`PL2C_WAYS-1];
  reg [2:0] state_q;
  reg [`PL2C_SET_W-1:0] sweep_q;
  reg [6:0] cnt_rd_q, cnt_wr_q, cnt_dvm_q;
  reg [5:0] cnt_snp_q;
  reg [7:0] bias_q;
  reg [`PL2C_PA_W-1:0] vpa_q;
  reg vtr_q;

  // Index and tag come from the physical address only
  wire [`PL2C_SET_W-1:0] set_w = req_pa_i[`PL2C_OFF_W+`PL2C_SET_W-1:`PL2C_OFF_W];
  wire [`PL2C_TAG_W-1:0] tag_w = req_pa_i[`PL2C_PA_W-1:`PL2C_OFF_W+`PL2C_SET_W];
  wire [`PL2C_BANK_W-1:0] bank_w = req_pa_i[`PL2C_OFF_W+`PL2C_BANK_W-1:`PL2C_OFF_W];
  // Downgrade: both levels write-back, data cache on
  wire cacheable_w = (req_inner_i == `PL2C_ATTR_WB) && (req_outer_i == `PL2C_ATTR_WB) && l1d_enable_i;
  wire is_snp_w = (req_src_i == `PL2C_SRC_SNP);
  wire [6:0] total_w = cnt_rd_q + cnt_wr_q + cnt_dvm_q;

  // Check bits: folded xor of tag and state, always written
  function [`PL2C_ECC_W-1:0] pl2c_ecc;
    input [`PL2C_TAG_W-1:0] t;
    input [1:0] s;
    begin
      pl2c_ecc = t[9:0] ^ t[19:10] ^ t[29:20] ^ {7'h00, t[30], s};
    end
  endfunction

  // Lookup across the ways of the addressed set
  reg hit_w;
  reg [`PL2C_WAY_W-1:0] hway_w, vway_w;
  reg inv_found_w;
  integer w;
  always @* begin
    hit_w = 1'b0;
    hway_w = 3'h0;
    inv_found_w = 1'b0;
    vway_w = bias_q[2:0];
    for (w = 0; w < `PL2C_WAYS; w = w + 1) begin
      if (st_mem[{set_w, w[2:0]}] != `PL2C_ST_I && tag_mem[{set_w, w[2:0]}] == tag_w) begin
        hit_w = 1'b1;
        hway_w = w[2:0];
      end
    end
    // Biased victim: invalid first, else a transient line, else rotating pick
    for (w = `PL2C_WAYS - 1; w >= 0; w = w - 1) begin
      if (tr_mem[{set_w, w[2:0]}] && !inv_found_w) begin
        vway_w = w[2:0];
      end
    end
    for (w = `PL2C_WAYS - 1; w >= 0; w = w - 1) begin
      if (st_mem[{set_w, w[2:0]}] == `PL2C_ST_I) begin
        vway_w = w[2:0];
        inv_found_w = 1'b1;
      end
    end
  end

  // Limit check for a new link transaction
  reg room_w;
  always @* begin
    room_w = total_w < `PL2C_MAX_TOTAL;
    case (req_op_i)
      `PL2C_OP_RD: room_w = room_w && (cnt_rd_q < `PL2C_MAX_RD);
      `PL2C_OP_WR: room_w = room_w && (cnt_wr_q < `PL2C_MAX_WR);
      default: room_w = room_w && (cnt_dvm_q < `PL2C_MAX_DVM);
    endcase
    if (is_snp_w) begin
      room_w = cnt_snp_q < `PL2C_MAX_SNP;
    end
  end

  wire vic_valid_w = st_mem[{set_w, vway_w}] != `PL2C_ST_I;
  wire need_link_w = !is_snp_w && (!hit_w || !cacheable_w || req_op_i == `PL2C_OP_DVM);
  wire alloc_cand_w = !is_snp_w && cacheable_w && !hit_w && req_op_i != `PL2C_OP_DVM;
  // An allocation that displaces a valid line needs room for its eviction write as well
  wire evict_room_w = (total_w < `PL2C_MAX_TOTAL - 7'h01) && (cnt_wr_q < `PL2C_MAX_WR - 7'h01);
  // Ready is a registered pulse, so a request still held in that cycle must not be taken twice
  wire take_w = (state_q == S_IDLE) && req_valid_i && !req_ready_o && (!need_link_w || room_w)
    && (!is_snp_w || room_w) && (!alloc_cand_w || !vic_valid_w || evict_room_w);
  wire alloc_w = take_w && !is_snp_w && cacheable_w && !hit_w && req_op_i != `PL2C_OP_DVM;
  wire rd_issue_w = take_w && need_link_w && req_op_i == `PL2C_OP_RD;
  wire wr_issue_w = take_w && need_link_w && req_op_i == `PL2C_OP_WR;
  wire dvm_issue_w = take_w && need_link_w && req_op_i == `PL2C_OP_DVM;
  wire snp_take_w = take_w && is_snp_w;

  // Outstanding counters; issue and completion in one cycle cancel
  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt_rd_q <= 7'h00;
      cnt_wr_q <= 7'h00;
      cnt_dvm_q <= 7'h00;
      cnt_snp_q <= 6'h00;
    end else begin
      cnt_rd_q <= cnt_rd_q + {6'h00, rd_issue_w} - {6'h00, rd_done_i && cnt_rd_q != 7'h00};
      cnt_wr_q <= cnt_wr_q + {6'h00, wr_issue_w || (state_q == S_EVIC)}
        - {6'h00, wr_done_i && cnt_wr_q != 7'h00};
      cnt_dvm_q <= cnt_dvm_q + {6'h00, dvm_issue_w} - {6'h00, dvm_done_i && cnt_dvm_q != 7'h00};
      cnt_snp_q <= cnt_snp_q + {5'h00, snp_take_w} - {5'h00, snp_done_i && cnt_snp_q != 6'h00};
    end
  end

  // Control, cache store update and outputs
  always @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= S_INIT;
      sweep_q <= 11'h000;
      bias_q <= 8'h00;
      vpa_q <= 48'h000000000000;
      vtr_q <= 1'b0;
      req_ready_o <= 1'b0;
      rsp_valid_o <= 1'b0;
      rsp_hit_o <= 1'b0;
      rsp_cacheable_o <= 1'b0;
      rsp_l1_prefer_evict_o <= 1'b0;
      rsp_state_o <= `PL2C_ST_I;
      rsp_bank_o <= 2'h0;
      rsp_way_o <= 3'h0;
      rsp_ecc_o <= 10'h000;
      link_req_o <= 1'b0;
      link_op_o <= `PL2C_OP_RD;
      link_pa_o <= 48'h000000000000;
      link_no_alloc_o <= 1'b0;
      l1i_inval_o <= 1'b0;
      l1d_inval_o <= 1'b0;
      l1_inval_pa_o <= 48'h000000000000;
      busy_o <= 1'b1;
    end else begin
      rsp_valid_o <= take_w;
      link_req_o <= 1'b0;
      link_no_alloc_o <= 1'b0;
      l1i_inval_o <= 1'b0;
      l1d_inval_o <= 1'b0;
      bias_q <= bias_q + 8'h01;
      req_ready_o <= 1'b0;
      case (state_q)
        S_INIT: begin
          // Reset sweep, skipped in debug recovery mode
          busy_o <= 1'b1;
          if (dbg_recovery_i) begin
            state_q <= S_IDLE;
            busy_o <= 1'b0;
          end else begin
            for (w = 0; w < `PL2C_WAYS; w = w + 1) begin
              st_mem[{sweep_q, w[2:0]}] <= `PL2C_ST_I;
              tr_mem[{sweep_q, w[2:0]}] <= 1'b0;
            end
            sweep_q <= sweep_q + 11'h001;
            if (sweep_q == 11'h7ff) begin
              state_q <= S_IDLE;
              busy_o <= 1'b0;
            end
          end
        end
        S_IDLE: begin
          // One unified pipe for instruction, data, walk and snoop
          req_ready_o <= take_w;
          if (take_w) begin
            rsp_hit_o <= hit_w;
            rsp_cacheable_o <= cacheable_w && !is_snp_w;
            rsp_bank_o <= bank_w;
            rsp_way_o <= hit_w ? hway_w : vway_w;
            rsp_state_o <= hit_w ? st_mem[{set_w, hway_w}] : `PL2C_ST_I;
            rsp_ecc_o <= hit_w ? ecc_mem[{set_w, hway_w}] : 10'h000;
            // Transient read still allocates first level, marked preferred victim
            rsp_l1_prefer_evict_o <= req_transient_i && cacheable_w && req_src_i == `PL2C_SRC_DAT;
            if (need_link_w) begin
              link_req_o <= 1'b1;
              link_op_o <= req_op_i;
              link_pa_o <= req_pa_i;
            end
            if (is_snp_w && hit_w) begin
              // Snoop: drop to shared or invalid per protocol
              st_mem[{set_w, hway_w}] <= (req_op_i == `PL2C_OP_RD) ? `PL2C_ST_S : `PL2C_ST_I;
              ecc_mem[{set_w, hway_w}] <= pl2c_ecc(tag_w, (req_op_i == `PL2C_OP_RD) ? `PL2C_ST_S : `PL2C_ST_I);
              l1d_inval_o <= req_op_i != `PL2C_OP_RD;
              l1i_inval_o <= (req_op_i != `PL2C_OP_RD) && (INSTR_CACHE_COHERENCY_PARAM != 0);
              l1_inval_pa_o <= req_pa_i;
            end else if (hit_w && cacheable_w && req_op_i == `PL2C_OP_WR) begin
              st_mem[{set_w, hway_w}] <= `PL2C_ST_M;
              ecc_mem[{set_w, hway_w}] <= pl2c_ecc(tag_w, `PL2C_ST_M);
            end
            if (alloc_w) begin
              // Fill, including instruction fetches into both levels
              tag_mem[{set_w, vway_w}] <= tag_w;
              st_mem[{set_w, vway_w}] <= (req_op_i == `PL2C_OP_WR) ? `PL2C_ST_M : `PL2C_ST_E;
              tr_mem[{set_w, vway_w}] <= req_transient_i;
              ecc_mem[{set_w, vway_w}] <= pl2c_ecc(tag_w, (req_op_i == `PL2C_OP_WR) ? `PL2C_ST_M : `PL2C_ST_E);
              if (vic_valid_w) begin
                vpa_q <= {tag_mem[{set_w, vway_w}], set_w, 6'h00};
                vtr_q <= tr_mem[{set_w, vway_w}];
                state_q <= S_EVIC;
              end
            end
          end
        end
        S_EVIC: begin
          // Victim leaves: back-invalidate data, instruction only if coherent
          l1d_inval_o <= 1'b1;
          l1i_inval_o <= INSTR_CACHE_COHERENCY_PARAM != 0;
          l1_inval_pa_o <= vpa_q;
          // Write-back always issued; room for it was reserved when the fill was taken
          link_req_o <= 1'b1;
          link_op_o <= `PL2C_OP_WR;
          link_pa_o <= vpa_q;
          link_no_alloc_o <= vtr_q;
          state_q <= S_IDLE;
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end
endmodule // pl2c_top

// ---- tb/pl2c_sva.sv ----
/*
  Port checker for the second-level cache controller, bound into pl2c_top.
  Assumes the core holds request fields until the ready pulse.
*/
`timescale 1ns/1ns
`include "pl2c_regs.vh"
module pl2c_sva #(parameter INSTR_CACHE_COHERENCY_PARAM = 0) (
  // Clock, reset and request side
  input wire clk_i, rst_i, dbg_recovery_i, req_valid_i, req_transient_i, l1d_enable_i,
  input wire [1:0] req_src_i, req_op_i, req_inner_i, req_outer_i,
  // Responses, link and invalidates
  input wire req_ready_o, rsp_valid_o, rsp_hit_o, rsp_cacheable_o, rsp_l1_prefer_evict_o,
  input wire link_req_o, link_no_alloc_o, l1i_inval_o, l1d_inval_o, busy_o,
  input wire [1:0] link_op_o,
  input wire rd_done_i, wr_done_i, dvm_done_i, snp_done_i
);
  int rd_q, wr_q, dvm_q, snp_q, sw_q;
  // Outstanding tallies; a completion at zero is dropped so a stray pulse cannot hide an overrun
  always @(posedge clk_i) begin
    if (rst_i) begin
      rd_q <= 0; wr_q <= 0; dvm_q <= 0; snp_q <= 0; sw_q <= 0;
    end else begin
      rd_q <= rd_q + (link_req_o && link_op_o == `PL2C_OP_RD) - (rd_done_i && rd_q != 0);
      wr_q <= wr_q + (link_req_o && link_op_o == `PL2C_OP_WR) - (wr_done_i && wr_q != 0);
      dvm_q <= dvm_q + (link_req_o && link_op_o == `PL2C_OP_DVM) - (dvm_done_i && dvm_q != 0);
      snp_q <= snp_q + (req_ready_o && req_src_i == `PL2C_SRC_SNP) - (snp_done_i && snp_q != 0);
      sw_q <= sw_q + busy_o;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Answer to a core request; dvm carries no memory type
  sequence s_core_rsp;
    rsp_valid_o && req_src_i != `PL2C_SRC_SNP && req_op_i != `PL2C_OP_DVM;
  endsequence
  sequence s_needs_link;
    rsp_valid_o && req_src_i != `PL2C_SRC_SNP && (!rsp_hit_o || !rsp_cacheable_o || req_op_i == `PL2C_OP_DVM);
  endsequence
  AST_RDY_RSP: assert property (req_ready_o |-> rsp_valid_o && $past(req_valid_i))
    else $error("ready without a request");
  AST_BUSY_HOLD: assert property (busy_o |-> !req_ready_o)
    else $error("request taken during sweep");
  AST_SWEEP_LEN: assert property ($fell(busy_o) |-> (dbg_recovery_i ? sw_q <= 3 :
    sw_q >= `PL2C_SETS - 1 && sw_q <= `PL2C_SETS + 2))
    else $error("sweep length wrong");
  AST_MEMTYPE: assert property (s_core_rsp |-> rsp_cacheable_o == (req_inner_i == `PL2C_ATTR_WB &&
    req_outer_i == `PL2C_ATTR_WB && l1d_enable_i)) else $error("memory type downgrade wrong");
  AST_LINK_NEED: assert property (s_needs_link |-> link_req_o)
    else $error("no link request for miss");
  AST_PREFER: assert property (rsp_valid_o && rsp_l1_prefer_evict_o |-> req_transient_i && rsp_cacheable_o)
    else $error("preferred victim without transient hint");
  AST_NOALLOC: assert property (link_no_alloc_o |-> link_req_o && link_op_o == `PL2C_OP_WR)
    else $error("no-allocate mark outside eviction write");
  AST_NO_L1I_INVAL: assert property (!(l1i_inval_o && INSTR_CACHE_COHERENCY_PARAM == 0))
    else $error("instruction back-invalidate in weak mode");
  AST_INVAL_CAUSE: assert property (l1d_inval_o |->
    (rsp_valid_o && req_src_i == `PL2C_SRC_SNP) || $past(rsp_valid_o && rsp_cacheable_o && !rsp_hit_o))
    else $error("stray invalidate");
  AST_LINK_LIMIT: assert property (rd_q + wr_q + dvm_q <= `PL2C_MAX_TOTAL)
    else $error("too many link transactions");
  AST_SNP_LIMIT: assert property (snp_q <= `PL2C_MAX_SNP)
    else $error("too many snoops accepted");
endmodule // pl2c_sva
bind pl2c_top pl2c_sva #(.INSTR_CACHE_COHERENCY_PARAM(INSTR_CACHE_COHERENCY_PARAM)) pl2c_sva_inst (.*);

// ---- tb/pl2c_link_model.sv ----
/*
  Interconnect completion model: one completion per type per cycle.
  Assumes link requests are one-cycle pulses; hold_i stalls it.
*/
`timescale 1ns/1ns
`include "pl2c_regs.vh"
module pl2c_link_model (
  input wire clk_i, rst_i, hold_i, link_req_i,
  input wire [1:0] link_op_i,
  output reg rd_done_o, wr_done_o, dvm_done_o
);
  integer rd_n, wr_n, dvm_n;
  // Completions follow issue per type; a stall lets the device fill its limits
  always @(posedge clk_i) begin
    if (rst_i) begin
      rd_n <= 0; wr_n <= 0; dvm_n <= 0;
      rd_done_o <= 1'h0; wr_done_o <= 1'h0; dvm_done_o <= 1'h0;
    end else begin
      rd_done_o <= !hold_i && rd_n > 0;
      wr_done_o <= !hold_i && wr_n > 0;
      dvm_done_o <= !hold_i && dvm_n > 0;
      rd_n <= rd_n + (link_req_i && link_op_i == `PL2C_OP_RD) - (!hold_i && rd_n > 0);
      wr_n <= wr_n + (link_req_i && link_op_i == `PL2C_OP_WR) - (!hold_i && wr_n > 0);
      dvm_n <= dvm_n + (link_req_i && link_op_i == `PL2C_OP_DVM) - (!hold_i && dvm_n > 0);
    end
  end
endmodule // pl2c_link_model

// ---- tb/pl2c_tb_top.sv ----
/*
  Self-checking bench for pl2c_top with a residency model and link model.
  Assumes the lines used map to distinct sets so no eviction disturbs hits.
*/
`timescale 1ns/1ns
`include "pl2c_regs.vh"
module pl2c_tb_top;
  reg clk_i = 0, rst_i = 1, dbg_recovery_i = 0, req_valid_i = 0, req_transient_i = 0, l1d_enable_i = 1;
  reg snp_done_i = 0, hold = 0, ok, hit, cac, lk, pre, ec;
  reg [1:0] req_src_i = 0, req_op_i = 0, req_inner_i = 0, req_outer_i = 0, lop, ii, oo, s;
  reg [47:0] req_pa_i = 0, a;
  reg [31:0] seed = 32'h0000f54f, r;
  wire req_ready_o, rsp_valid_o, rsp_hit_o, rsp_cacheable_o, rsp_l1_prefer_evict_o, link_req_o, busy_o;
  wire rd_done_i, wr_done_i, dvm_done_i, link_no_alloc_o, l1d_inval_o;
  wire [47:0] l1_inval_pa_o;
  wire [1:0] link_op_o;
  integer num_errors = 0, num_checks = 0, i, n, k;
  bit res [int];
  pl2c_top pl2c_top_inst (.rsp_state_o(), .rsp_bank_o(), .rsp_way_o(), .rsp_ecc_o(), .link_pa_o(),
    .l1i_inval_o(), .*);
  pl2c_link_model pl2c_link_model_inst (.clk_i(clk_i), .rst_i(rst_i), .hold_i(hold), .link_req_i(link_req_o),
    .link_op_i(link_op_o), .rd_done_o(rd_done_i), .wr_done_o(wr_done_i), .dvm_done_o(dvm_done_i));
  always #50 clk_i = ~clk_i;
  function [31:0] rnd;
    begin
      seed = seed ^ (seed << 13); seed = seed ^ (seed >> 17); seed = seed ^ (seed << 5); rnd = seed;
    end
  endfunction
  task chk(input [63:0] sv, ev);
    begin
      num_checks++;
      if (sv !== ev) begin
        num_errors++;
        $display("FAIL %0t seen %0h expected %0h", $time, sv, ev);
      end
    end
  endtask
  task wrap_up;
    begin
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  // Hold the request until the ready pulse or 30 cycles; the answer is taken at that same edge
  task rq(input [1:0] sr, op, ia, oa, input [47:0] pa, input t);
    begin
      @(posedge clk_i);
      req_valid_i <= 1; req_src_i <= sr; req_op_i <= op; req_inner_i <= ia; req_outer_i <= oa;
      req_pa_i <= pa; req_transient_i <= t; ok = 0; n = 0;
      while (!ok && n < 30) begin
        @(posedge clk_i); n++; ok = req_ready_o === 1'b1;
      end
      hit = rsp_hit_o; cac = rsp_cacheable_o; lk = link_req_o; lop = link_op_o; pre = rsp_l1_prefer_evict_o;
      req_valid_i <= 0;
    end
  endtask
  task reset(input d);
    begin
      @(posedge clk_i); rst_i <= 1; dbg_recovery_i <= d;
      repeat (8) @(posedge clk_i);
      rst_i <= 0; n = 0;
      @(posedge clk_i);
      while (busy_o !== 1'b0 && n < 2100) begin
        @(posedge clk_i); n++;
      end
      chk(d ? n <= 3 : n >= `PL2C_SETS - 1 && n <= `PL2C_SETS + 1, 1);
    end
  endtask
  initial begin
    reset(0);
    // Random memory types over 32 lines in distinct sets
    for (i = 0; i < 150; i++) begin
      r = rnd(); a = {37'h0, r[4:0], 6'h00}; ii = r[9:8] % 2'h3; oo = r[11:10] % 2'h3; s = {1'b0, r[15]};
      l1d_enable_i <= r[12] | r[13];
      ec = ii == `PL2C_ATTR_WB && oo == `PL2C_ATTR_WB && (r[12] | r[13]);
      rq(s, `PL2C_OP_RD, ii, oo, a, r[14]);
      chk(cac, ec);
      if (ec) chk(hit, res.exists(r[4:0]));
      chk(lk, !ec || !res.exists(r[4:0]));
      if (ec && !res.exists(r[4:0]) && s == `PL2C_SRC_DAT) chk(pre, r[14]);
      if (ec) res[r[4:0]] = 1;
    end
    l1d_enable_i <= 1;
    for (i = 0; i < 3; i++) begin
      rq(`PL2C_SRC_DAT, i[1:0], 2'h0, 2'h0, 48'h100000 + i * 64, 0);
      chk({lk, lop}, {1'b1, i[1:0]});
    end
    repeat (40) @(posedge clk_i);
    hold <= 1;
    for (i = 0; i < 93; i++) begin
      rq(`PL2C_SRC_DAT, `PL2C_OP_RD, 2'h0, 2'h0, 48'h200000, 0);
      chk(ok, i < 92);
    end
    hold <= 0;
    rq(`PL2C_SRC_DAT, `PL2C_OP_RD, 2'h0, 2'h0, 48'h200000, 0);
    chk(ok, 1);
    // Snoops without completion until the acceptance limit
    for (i = 0; i < 54; i++) begin
      rq(`PL2C_SRC_SNP, 2'h0, 2'h2, 2'h2, 48'h300000 + i * 64, 0);
      chk(ok, i < 53);
    end
    @(posedge clk_i) snp_done_i <= 1;
    @(posedge clk_i) snp_done_i <= 0;
    rq(`PL2C_SRC_SNP, 2'h1, 2'h2, 2'h2, 48'h300000, 0);
    chk(ok, 1);
    void'(res.first(k));
    reset(1);
    rq(`PL2C_SRC_DAT, `PL2C_OP_RD, 2'h2, 2'h2, {37'h0, k[4:0], 6'h00}, 0);
    chk(hit, 1);
    reset(0);
    rq(`PL2C_SRC_DAT, `PL2C_OP_RD, 2'h2, 2'h2, {37'h0, k[4:0], 6'h00}, 0);
    chk(hit, 0);
    // Nine tags in one set force an eviction of the transient line
    for (i = 0; i < 9; i++) begin
      rq(`PL2C_SRC_DAT, `PL2C_OP_RD, 2'h2, 2'h2, {20'h0, i[7:0], 20'h10000}, i == 0);
      chk(ok, 1);
    end
    // The transient first line is the victim: data invalidate and no-allocate write-back
    @(posedge clk_i);
    chk({l1d_inval_o, link_no_alloc_o, l1_inval_pa_o}, {2'b11, 48'h000000010000});
    repeat (5) @(posedge clk_i);
    wrap_up;
  end
  initial begin
    #6000000;
    num_errors++;
    wrap_up;
  end
endmodule // pl2c_tb_top
